// [src/afr_top.sv]
// One-to-four address register and driver with three-state output groups
`include "afr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module afr_top
   import afr_pkg::*;
(
   input wire logic core_clk,                    // System clock, 125 MHz
   input wire logic rst_n,                       // Synchronous reset, active low
   input wire afr_pkg::afr_in_s addr_pin,        // Address pins with driven flags
   input wire logic sel_pin,                     // Mode select pin, high is buffer
   input wire logic [`AFR_OE_CNT-1:0] oe_n_pin,  // Output enable pins, active low
   input wire logic cap_clk_pin,                 // Capture clock pin
   output afr_pkg::afr_out_s y                   // Output groups and enables
);

   import afr_pkg::*;

   // Synchronised and held address word
   afr_addr_t addr_held;
   // Synchronised control pins
   logic [`AFR_CTRL_W-1:0] ctrl_raw;
   logic [`AFR_CTRL_W-1:0] ctrl_s;
   logic sel_s;                          // Mode select after sync
   logic [`AFR_OE_CNT-1:0] oe_n_s;       // Enables after sync
   logic cap_clk_s;                      // Capture clock after sync
   logic clk_rise;                       // One-cycle pulse on a capture edge
   // Output register and its next value
   afr_out_s y_ff;
   afr_out_s nxt_y;
   // Previous capture clock level for edge detection
   logic clk_prev_ff;
   logic nxt_clk_prev;
   // Capture flip-flops, deliberately without reset
   afr_addr_t cap_ff;
   afr_addr_t nxt_cap;

   // Address pins: synchronise and apply bus-hold
   // bus hold
   afr_sync_hold #(
      .W(`AFR_ADDR_W)
   ) u_addr_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_val(addr_pin.data),
      .pin_drv(addr_pin.drv),
      .held(addr_held)
   );

   // Control pins are always driven, so the hold path engages only while the driven flags flush after reset
   assign ctrl_raw = {cap_clk_pin, oe_n_pin, sel_pin};

   // Control pin synchroniser; it resets to enables off so the groups
   // cannot drive in the cycles before the real pin levels arrive
   // float through reset
   afr_sync_hold #(
      .W(`AFR_CTRL_W),
      .RST_VAL(`AFR_CTRL_RST)
   ) u_ctrl_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_val(ctrl_raw),
      .pin_drv({`AFR_CTRL_W{`AFR_DRV_ON}}),
      .held(ctrl_s)
   );

   // Split the synchronised control word
   assign sel_s = ctrl_s[`AFR_CTRL_SEL];
   assign oe_n_s = ctrl_s[`AFR_CTRL_OE_HI:`AFR_CTRL_OE_LO];
   assign cap_clk_s = ctrl_s[`AFR_CTRL_CLK];

   // Rising edge of the synchronised capture clock
   assign clk_rise = cap_clk_s & ~clk_prev_ff;

   // Capture next value: depends only on the edge, never on select or enables
   // capture on edge
   always_comb begin
      nxt_cap = cap_ff;
      if (clk_rise) begin
         nxt_cap = addr_held;
      end
   end

   // Capture register; starts undefined until the first edge
   // no reset
   always_ff @(posedge core_clk) begin
      cap_ff <= nxt_cap;
   end

   // Edge detector next value
   always_comb begin
      nxt_clk_prev = cap_clk_s;
      if (!rst_n) begin
         // Start high so a pin already high is not taken as an edge
         nxt_clk_prev = `AFR_CLK_PREV_RST;
      end
   end

   // Edge detector register
   always_ff @(posedge core_clk) begin
      clk_prev_ff <= nxt_clk_prev;
   end

   // Output next values: mode picks the source, enables gate each group
   always_comb begin
      nxt_y = y_ff;
      if (!rst_n) begin
         // Groups float and read low during reset
         nxt_y.oe = `AFR_OE_RST;
         for (int g = 0; g < `AFR_GRP_CNT; g++) begin
            nxt_y.data[g] = `AFR_DATA_RST;
         end
      end else begin
         for (int g = 0; g < `AFR_GRP_CNT; g++) begin
            if (sel_s) begin
               nxt_y.data[g] = addr_held;
            end else begin
               nxt_y.data[g] = cap_ff;
            end
            nxt_y.oe[g] = ~oe_n_s[g / `AFR_GRP_PER_OE];
         end
      end
   end

   // Output register, the only source of the outputs
   always_ff @(posedge core_clk) begin
      y_ff <= nxt_y;
   end

   assign y = y_ff;

   // Capture followed by a register-mode cycle
   sequence s_reg_capture;
      $past(rst_n) && clk_rise && !sel_s ##1 !sel_s;
   endsequence

   // Live data taken in buffer mode
   sequence s_buffer_cycle;
      $past(rst_n) && rst_n && sel_s;
   endsequence

   // All four groups always carry the same word, undefined words included
   a_fanout_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> (y_ff.data[1] === y_ff.data[0] && y_ff.data[2] === y_ff.data[0]
         && y_ff.data[3] === y_ff.data[0]))
      else $error("output groups differ");

   // Buffer mode shows the live word one cycle later
   a_buffer_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_buffer_cycle |=> y_ff.data[0] == $past(addr_held))
      else $error("buffer mode output does not follow input");

   // Register mode shows the word captured two cycles earlier
   a_reg_present: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_reg_capture |=> y_ff.data[2] == $past(addr_held, 2))
      else $error("register mode output is not the captured word");

   // A capture edge loads the held word
   a_capture_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(rst_n) && clk_rise) |=> cap_ff == $past(addr_held))
      else $error("capture edge did not load input");

   // Without an edge the captured word stays, checked in buffer mode or with an enable high
   a_capture_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!clk_rise && (sel_s || oe_n_s != 2'h0)) |=> cap_ff === $past(cap_ff))
      else $error("captured word changed without an edge");

   // Low enable drives both of its groups
   a_oe_drive_lo: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(rst_n) && !oe_n_s[0]) |=> (y_ff.oe[0] && y_ff.oe[1]))
      else $error("first enable low but its groups do not drive");

   // High enable floats both of its groups
   a_oe_float_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(rst_n) && oe_n_s[1]) |=> (!y_ff.oe[2] && !y_ff.oe[3]))
      else $error("second enable high but its groups drive");

   // Each enable governs exactly its own pair of groups
   a_oe_pairing: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> (y_ff.oe[0] == y_ff.oe[1] && y_ff.oe[2] == y_ff.oe[3]
         && y_ff.oe[0] == !$past(oe_n_s[0]) && y_ff.oe[2] == !$past(oe_n_s[1])))
      else $error("enable grouping broken");

endmodule : afr_top

`default_nettype wire

// [common/afr_cfg.svh]
// Shared constants for the address fan-out register driver
`ifndef AFR_CFG_SVH
`define AFR_CFG_SVH

// Width of one address word on the input pins
`define AFR_ADDR_W 7
// Number of copies made of each address word
`define AFR_GRP_CNT 4
// Number of active-low output enable pins
`define AFR_OE_CNT 2
// Output groups governed by one output enable
`define AFR_GRP_PER_OE 2
// Depth of every pin synchroniser
`define AFR_SYNC_DEPTH 2
// Number of control pins passed through one synchroniser
`define AFR_CTRL_W 4
// Bit positions inside the control synchroniser word
`define AFR_CTRL_SEL 0
`define AFR_CTRL_OE_LO 1
`define AFR_CTRL_OE_HI 2
`define AFR_CTRL_CLK 3
// Reset values
`define AFR_OE_RST 4'h0
`define AFR_DATA_RST 7'h00
`define AFR_SYNC_RST 1'b0
`define AFR_CLK_PREV_RST 1'b1
// Control word shown while the synchroniser flushes after reset:
// enables off, capture clock seen high (no false edge), buffer mode
`define AFR_CTRL_RST 4'hf
// Level meaning a pin is actively driven
`define AFR_DRV_ON 1'b1

`endif

// [common/afr_pkg.sv]
// Types shared by the address fan-out register driver
`include "afr_cfg.svh"

package afr_pkg;

   // One address word
   typedef logic [`AFR_ADDR_W-1:0] afr_addr_t;

   // Address pins: level and a per-bit driven flag from the wire resolution
   typedef struct packed {
      afr_addr_t data;   // Level seen on each pin
      afr_addr_t drv;    // High where something drives the pin
   } afr_in_s;

   // Three-state outputs: four copies and one enable per copy
   typedef struct packed {
      afr_addr_t [`AFR_GRP_CNT-1:0] data;   // Output levels per group
      logic [`AFR_GRP_CNT-1:0] oe;          // High while the group drives
   } afr_out_s;

endpackage : afr_pkg

// [src/afr_sync_hold.sv]
// Two-stage pin synchroniser with bus-hold on undriven bits
`include "afr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module afr_sync_hold #(
   parameter int W = 1,                                  // Number of pins
   parameter logic [W-1:0] RST_VAL = {W{`AFR_SYNC_RST}}  // Levels shown until pins arrive
) (
   input wire logic core_clk,        // System clock
   input wire logic rst_n,           // Synchronous reset, active low
   input wire logic [W-1:0] pin_val, // Raw pin levels
   input wire logic [W-1:0] pin_drv, // Raw driven flags
   output logic [W-1:0] held         // Synchronised level, held when floating
);

   logic [W-1:0] val_s1_ff;   // First stage, read only by second stage
   logic [W-1:0] val_s2_ff;   // Second stage level
   logic [W-1:0] drv_s1_ff;   // First stage of driven flag
   logic [W-1:0] drv_s2_ff;   // Second stage of driven flag
   logic [W-1:0] hold_ff;     // Last valid level per bit
   logic [W-1:0] nxt_val_s1;
   logic [W-1:0] nxt_val_s2;
   logic [W-1:0] nxt_drv_s1;
   logic [W-1:0] nxt_drv_s2;
   logic [W-1:0] nxt_hold;

   // Driven bits pass the live level, floating bits keep the last one
   // bus hold
   always_comb begin
      for (int i = 0; i < W; i++) begin
         held[i] = (drv_s2_ff[i] == `AFR_DRV_ON) ? val_s2_ff[i] : hold_ff[i];
      end
   end

   // Next values of the synchroniser and hold stages
   always_comb begin
      nxt_val_s1 = pin_val;
      nxt_val_s2 = val_s1_ff;
      nxt_drv_s1 = pin_drv;
      nxt_drv_s2 = drv_s1_ff;
      nxt_hold = held;
      if (!rst_n) begin
         // Level stages and hold start at the chosen safe levels
         nxt_val_s1 = RST_VAL;
         nxt_val_s2 = RST_VAL;
         nxt_drv_s1 = {W{`AFR_SYNC_RST}};
         nxt_drv_s2 = {W{`AFR_SYNC_RST}};
         nxt_hold = RST_VAL;
      end
   end

   // Register stage
   always_ff @(posedge core_clk) begin
      val_s1_ff <= nxt_val_s1;
      val_s2_ff <= nxt_val_s2;
      drv_s1_ff <= nxt_drv_s1;
      drv_s2_ff <= nxt_drv_s2;
      hold_ff <= nxt_hold;
   end

   // With every bit floating, the word keeps its previous level
   a_bus_hold_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(rst_n) && drv_s2_ff == {W{1'b0}}) |-> held == $past(held))
      else $error("floating input did not hold its level");

endmodule : afr_sync_hold

`default_nettype wire

// [tb/afr_load_model.sv]
// Model of the four memory loads on the three-state output groups
`include "afr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module afr_load_model
   import afr_pkg::*;
(
   input wire logic core_clk,                              // System clock
   input wire afr_pkg::afr_out_s y,                        // Output groups from the driver
   output afr_pkg::afr_addr_t [`AFR_GRP_CNT-1:0] load_bus  // Level seen by each load
);
   // Last level per load, so a floating wire never shows a stale match
   afr_addr_t [`AFR_GRP_CNT-1:0] last_ff = '0;

   // driven group gives its level, floating group flips
   always_comb begin
      for (int g = 0; g < `AFR_GRP_CNT; g++) begin
         load_bus[g] = y.oe[g] ? y.data[g] : ~last_ff[g];
      end
   end

   // Remembers what each load saw on the last cycle
   always_ff @(posedge core_clk) begin
      last_ff <= load_bus;
   end
endmodule : afr_load_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the address fan-out register driver
`include "afr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("CHECK FAILED %0t %s", $time, m); end end

module tb_top;
   import afr_pkg::*;
   logic core_clk = 1'b0;          // System clock
   logic rst_n = 1'b0;             // Reset, active low
   afr_in_s addr_in = '0;          // Address pins with driven flags
   logic sel = 1'b1;               // Mode select, high is buffer
   logic [1:0] oe_n = 2'b11;       // Output enables, active low
   logic cap_clk = 1'b0;           // Capture clock pin
   afr_out_s y;                    // Output groups
   afr_addr_t [3:0] load_bus;      // Levels seen by the loads
   afr_addr_t live;                // Word now on the pins
   afr_addr_t held;                // Word last captured
   afr_addr_t w;                   // Scratch word
   int n_fail = 0;                 // Mismatches
   int comparisons = 0;            // Compares made
   int cycles = 0;                 // Run length guard

   // Clock of 8 ns period
   always #4 core_clk = ~core_clk;

   afr_top dut (.core_clk(core_clk), .rst_n(rst_n), .addr_pin(addr_in), .sel_pin(sel),
      .oe_n_pin(oe_n), .cap_clk_pin(cap_clk), .y(y));
   afr_load_model loads (.core_clk(core_clk), .y(y), .load_bus(load_bus));

   // Moves just past a number of rising edges
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   // Drives a word with every bit driven
   task automatic put(input afr_addr_t v);
      addr_in.data = v;
      addr_in.drv = 7'h7f;
      live = v;
   endtask : put

   // One capture edge, high and low each held three samples
   task automatic cap_pulse();
      cap_clk = 1'b1;
      step(3);
      cap_clk = 1'b0;
      step(3);
      held = live;
   endtask : cap_pulse

   // Lets pins settle, then checks every group enable, and each driving group against a word
   task automatic check_out(input afr_addr_t exp_w);
      step(5);
      for (int g = 0; g < 4; g++) begin
         `CHK(y.oe[g], ~oe_n[g / 2], "group enable")
         if (oe_n[g / 2] == 1'b0) `CHK(load_bus[g], exp_w, "group data")
      end
   endtask : check_out

   // Expected pin word when undriven bits keep an old level
   function automatic afr_addr_t hold_mix(input afr_addr_t old_w, input afr_addr_t drv,
      input afr_addr_t val);
      return (val & drv) | (old_w & ~drv);
   endfunction : hold_mix

   // Prints counts and verdict, then stops
   task automatic tally_and_finish();
      $display("counts: %0d mismatches in %0d compares", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // Cuts a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(32'hd2f1));
      step(16);
      rst_n = 1'b1;
      step(1);
      `CHK(y.oe, 4'h0, "outputs float after reset")
      // Buffer mode with corner words first, then random words and enables
      for (int i = 0; i < 40; i++) begin
         w = afr_addr_t'($urandom());
         put(i == 0 ? 7'h00 : i == 1 ? 7'h7f : i == 2 ? 7'h55 : w);
         oe_n = (i < 4) ? i[1:0] : 2'($urandom());
         check_out(live);
      end
      $display("buffer test done");
      // Register mode: new pins without an edge must not show
      sel = 1'b0;
      oe_n = 2'b00;
      for (int i = 0; i < 10; i++) begin
         put(afr_addr_t'($urandom()));
         cap_pulse();
         put(~held);
         check_out(held);
      end
      $display("register test done");
      // Capture while floating and in buffer mode still lands
      oe_n = 2'b11;
      sel = 1'b1;
      put(afr_addr_t'($urandom()));
      cap_pulse();
      sel = 1'b0;
      put(~held);
      oe_n = 2'b00;
      check_out(held);
      $display("capture while floating test done");
      // Floating pins keep their last level, fully and in part
      sel = 1'b1;
      put(7'h5a);
      step(5);
      addr_in.drv = 7'h00;
      addr_in.data = 7'h25;
      check_out(hold_mix(7'h5a, 7'h00, 7'h25));
      addr_in.drv = 7'h0f;
      addr_in.data = 7'h33;
      check_out(hold_mix(7'h5a, 7'h0f, 7'h33));
      $display("hold test done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
